/* File: common/haptic_readback_pkg.sv */
// Purpose: Shared constants and types of the haptic read-back register group.
// Assumes: 200 MHz system clock; 8-bit register addresses and data.
// Notes:   Every offset, field position, reset value and timing count lives here.

package haptic_readback_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_IMPEDANCE = 8'h03;
    localparam logic [7:0] ADDR_SUPPLY = 8'h04;
    localparam logic [7:0] ADDR_PERIOD_UPPER = 8'h05;
    localparam logic [7:0] ADDR_PERIOD_LOWER = 8'h06;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int PERIOD_W = 10;
    localparam int PERIOD_UPPER_LSB = 8;
    localparam int PERIOD_UPPER_W = 2;
    localparam logic [7:0] IMPEDANCE_RST = 8'h00;
    localparam logic [7:0] SUPPLY_RST = 8'h00;
    localparam logic [9:0] PERIOD_RST = 10'h000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] MODE_DIAGNOSTICS = 2'h2;

    // ----------------------------------------------------------------
    // Averaging and timing
    // ----------------------------------------------------------------
    localparam int AVG_DEPTH = 4;
    localparam real CLK_FREQ_MHZ = 200.0;
    localparam real PERIOD_STEP_US = 24.39;
    localparam int PERIOD_STEP_CYCLES = int'(PERIOD_STEP_US * CLK_FREQ_MHZ);

    typedef enum logic [0:0] {
        PERIOD_LIVE = 1'b0,
        PERIOD_HELD = 1'b1
    } period_lock_e;

endpackage

/* File: hw/period_averager.sv */
// Purpose: Running average of the last few measured resonance periods.
// Assumes: DEPTH is a power of two; taps start at zero after reset.
// Notes:   Result is registered and updated one cycle after each sample.

`timescale 1ns/1ps

module period_averager #(
    parameter int WIDTH = haptic_readback_pkg::PERIOD_W,
    parameter int DEPTH = haptic_readback_pkg::AVG_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // Samples in
    input wire logic sample_valid,
    input wire logic [WIDTH-1:0] sample,
    input wire logic averaging_disable,
    // Result out
    output logic [WIDTH-1:0] result,
    output logic result_valid
);

    localparam int SHIFT = $clog2(DEPTH);
    localparam int SUM_W = WIDTH + SHIFT;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] taps;
        logic [WIDTH-1:0] result;
        logic valid;
    } avg_state_s;

    avg_state_s st_r;
    avg_state_s st_nxt;
    logic [DEPTH-1:0][WIDTH-1:0] taps_shifted;
    logic [SUM_W-1:0] sum;

    // ----------------------------------------------------------------
    // Shift line
    // ----------------------------------------------------------------
    assign taps_shifted[0] = sample;
    generate
        for (genvar i = 1; i < DEPTH; i++)
        begin : g_tap
            assign taps_shifted[i] = st_r.taps[i-1];
        end
    endgenerate

    always_comb
    begin
        sum = '0;
        for (int i = 0; i < DEPTH; i++)
        begin
            sum = sum + SUM_W'(taps_shifted[i]);
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        if (sample_valid)
        begin
            st_nxt.taps = taps_shifted;
            st_nxt.valid = 1'b1;
            // Zero taps drag early averages low until the line fills
            if (averaging_disable)
                st_nxt.result = sample;
            else
                st_nxt.result = sum[SUM_W-1:SHIFT];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end

    assign result = st_r.result;
    assign result_valid = st_r.valid;

endmodule // period_averager

/* File: hw/haptic_readback_registers.sv */
// Purpose: Read-back status registers of a haptic driver: impedance, supply, resonance period.
// Assumes: Register strobes come from the serial control slave, synchronous to clk_sys.
// Notes:   Period registers lock on an upper read and unlock on a lower read or waveform end.
//
// Notes on behaviour
// - Impedance read-only eight bits, resets to zero.
// - Supply reading updates only during playback; resets zero.
// - Ten-bit period: upper two at 0x05, lower 0x06.
// - Upper read freezes both; lower read releases.
// - Waveform end releases lock; updates resume next playback.
// - One period count equals 24.39 microseconds.
// - Mode 2 runs diagnostics; mode change during playback means standby.
// - Averaging bit picks four-period average or last.

`timescale 1ns/1ps

module haptic_readback_registers #(
    parameter int STEP_CYCLES = haptic_readback_pkg::PERIOD_STEP_CYCLES,
    parameter int PERIOD_W = haptic_readback_pkg::PERIOD_W
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // Register access from the control bus slave
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [haptic_readback_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [haptic_readback_pkg::DATA_W-1:0] reg_wdata,
    output logic [haptic_readback_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Playback state
    input wire logic playing,
    input wire logic braking,
    input wire logic [1:0] mode,
    input wire logic period_averaging_disable,
    // Measurement inputs
    input wire logic diag_done,
    input wire logic [7:0] diag_impedance,
    input wire logic supply_sample_valid,
    input wire logic [7:0] supply_sample,
    input wire logic resonance_edge,
    // Status out
    output logic period_locked,
    output logic standby_req
);

    localparam int STEP_W = $clog2(STEP_CYCLES + 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
    localparam logic [PERIOD_W-1:0] MEAS_MAX = '1;

    typedef struct packed {
        logic [7:0] impedance;
        logic [7:0] supply;
        logic [PERIOD_W-1:0] period_shown;
        haptic_readback_pkg::period_lock_e lock;
        logic [STEP_W-1:0] step_cnt;
        logic [PERIOD_W-1:0] meas_cnt;
        logic meas_armed;
        logic meas_push;
        logic [PERIOD_W-1:0] meas_sample;
        logic playing_q;
        logic [1:0] mode_q;
        logic [7:0] rdata;
        logic rvalid;
        logic standby_req;
    } regs_state_s;

    localparam regs_state_s STATE_RST = '{
        impedance: haptic_readback_pkg::IMPEDANCE_RST,
        supply: haptic_readback_pkg::SUPPLY_RST,
        period_shown: haptic_readback_pkg::PERIOD_RST,
        lock: haptic_readback_pkg::PERIOD_LIVE,
        step_cnt: '0,
        meas_cnt: '0,
        meas_armed: 1'b0,
        meas_push: 1'b0,
        meas_sample: '0,
        playing_q: 1'b0,
        mode_q: haptic_readback_pkg::MODE_RST,
        rdata: 8'h00,
        rvalid: 1'b0,
        standby_req: 1'b0
    };

    regs_state_s st_r;
    regs_state_s st_nxt;
    logic [PERIOD_W-1:0] avg_result;
    logic avg_valid;

    // Address match, shared by the read mux and the lock logic
    function automatic logic addr_is(
        input logic [haptic_readback_pkg::ADDR_W-1:0] addr,
        input logic [haptic_readback_pkg::ADDR_W-1:0] target
    );
        addr_is = (addr == target);
    endfunction

    // ----------------------------------------------------------------
    // Period averaging
    // ----------------------------------------------------------------
    period_averager #(
        .WIDTH(PERIOD_W),
        .DEPTH(haptic_readback_pkg::AVG_DEPTH)
    ) u_period_averager (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .sample_valid(st_r.meas_push),
        .sample(st_r.meas_sample),
        .averaging_disable(period_averaging_disable),
        .result(avg_result),
        .result_valid(avg_valid)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.playing_q = playing;
        st_nxt.mode_q = mode;
        st_nxt.meas_push = 1'b0;
        st_nxt.rvalid = 1'b0;
        st_nxt.standby_req = 1'b0;

        // Mode switch while a process runs drops the device to standby
        if (playing && (mode != st_r.mode_q))
            st_nxt.standby_req = 1'b1;

        if (diag_done && (mode == haptic_readback_pkg::MODE_DIAGNOSTICS))
            st_nxt.impedance = diag_impedance;

        if (supply_sample_valid && playing)
            st_nxt.supply = supply_sample;

        // Period measured in steps of a fixed time base
        if (!playing)
        begin
            st_nxt.step_cnt = '0;
            st_nxt.meas_cnt = '0;
            st_nxt.meas_armed = 1'b0;
        end
        else if (resonance_edge)
        begin
            // First edge of a playback only starts the count
            st_nxt.meas_push = st_r.meas_armed;
            st_nxt.meas_sample = st_r.meas_cnt;
            st_nxt.meas_armed = 1'b1;
            st_nxt.step_cnt = '0;
            st_nxt.meas_cnt = '0;
        end
        else if (st_r.step_cnt == STEP_LAST)
        begin
            st_nxt.step_cnt = '0;
            // Saturate rather than wrap on a stalled actuator
            if (st_r.meas_cnt != MEAS_MAX)
                st_nxt.meas_cnt = st_r.meas_cnt + 1'b1;
        end
        else
        begin
            st_nxt.step_cnt = st_r.step_cnt + 1'b1;
        end

        // Shown value follows the averager only while unlocked
        if (avg_valid && (st_r.lock == haptic_readback_pkg::PERIOD_LIVE))
            st_nxt.period_shown = avg_result;

        // Waveform end frees a lock the host never closed
        if (st_r.playing_q && !playing)
            st_nxt.lock = haptic_readback_pkg::PERIOD_LIVE;

        // Writes land nowhere: every field here is read-only
        if (reg_rd)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = haptic_readback_pkg::UNMAPPED_RDATA;
            if (addr_is(reg_addr, haptic_readback_pkg::ADDR_IMPEDANCE))
                st_nxt.rdata = st_r.impedance;
            if (addr_is(reg_addr, haptic_readback_pkg::ADDR_SUPPLY))
                st_nxt.rdata = st_r.supply;
            if (addr_is(reg_addr, haptic_readback_pkg::ADDR_PERIOD_LOWER))
            begin
                st_nxt.rdata = st_r.period_shown[7:0];
                st_nxt.lock = haptic_readback_pkg::PERIOD_LIVE;
            end
            // Upper read comes last so its lock wins a same-cycle release
            if (addr_is(reg_addr, haptic_readback_pkg::ADDR_PERIOD_UPPER))
            begin
                st_nxt.rdata = {6'h00,
                    st_r.period_shown[haptic_readback_pkg::PERIOD_UPPER_LSB +: haptic_readback_pkg::PERIOD_UPPER_W]};
                st_nxt.lock = haptic_readback_pkg::PERIOD_HELD;
                // Freeze also blocks an averager result landing this cycle
                st_nxt.period_shown = st_r.period_shown;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= STATE_RST;
        else if (ce)
            st_r <= st_nxt;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign period_locked = (st_r.lock == haptic_readback_pkg::PERIOD_HELD);
    assign standby_req = st_r.standby_req;

    // Braking and write data carry no behaviour in this group
    logic unused_ok;
    assign unused_ok = braking ^ reg_wr ^ (^reg_wdata);

endmodule // haptic_readback_registers

/* File: tb/readback_asserts.sv */
// Purpose: Port checks of the read-back register group.
// Assumes: One clock domain, sys_rst async active high.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module readback_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Inputs watched
    input wire logic ce,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic playing,
    input wire logic [1:0] mode,
    // Outputs watched
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic period_locked,
    input wire logic standby_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ----
    // Assertions
    // ----
    sequence up_rd;
        ce && reg_rd && reg_addr == 8'h05;
    endsequence
    sequence calm;
        ce && !reg_rd;
    endsequence
    a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
        else $error("read unanswered");
    a_no_answer: assert property (calm |=> !reg_rvalid)
        else $error("stray read valid");
    a_upper_lock: assert property (up_rd |=> period_locked && reg_rdata[7:2] == 6'h00)
        else $error("upper read wrong");
    a_lower_free: assert property (ce && reg_rd && reg_addr == 8'h06 |=> !period_locked)
        else $error("lower read kept lock");
    a_lock_hold: assert property (period_locked && playing && ce && !reg_rd |=> period_locked)
        else $error("lock lost");
    a_write_inert: assert property (ce && reg_wr && !reg_rd && !period_locked |=> !period_locked)
        else $error("write changed lock");
    a_end_free: assert property (period_locked && $fell(playing) && ce && !reg_rd ##1 calm |=> !period_locked)
        else $error("lock kept after end");
    a_mode_stby: assert property (ce && playing && !$stable(mode) |=> standby_req)
        else $error("no standby request");
    a_quiet_stby: assert property (ce && $stable(mode) ##1 ce && $stable(mode) |=> !standby_req)
        else $error("stray standby request");
endmodule // readback_asserts
bind haptic_readback_registers readback_asserts readback_asserts_inst (.clk_sys, .sys_rst, .ce, .reg_rd,
    .reg_wr, .reg_addr, .playing, .mode, .reg_rdata, .reg_rvalid, .period_locked, .standby_req);

/* File: tb/host_model.sv */
// Purpose: Host side of the register access port.
// Assumes: One access in flight; answer within four cycles.
// Notes:   Address and data show their inverse when idle.
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clk_sys,
    // Access port
    output logic reg_rd = 1'b0,
    output logic reg_wr = 1'b0,
    output logic [7:0] reg_addr = 8'hff,
    output logic [7:0] reg_wdata = 8'hff,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        reg_rd <= !wr;
        reg_wr <= wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
        while (!wr && reg_rvalid !== 1'b1 && n < 4)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        q = reg_rdata;
    endtask
endmodule // host_model

/* File: tb/testbench.sv */
// Purpose: Self-checking bench of the read-back registers.
// Assumes: Period step shortened to four clocks.
// Notes:   Period reads go upper then lower, lower then upper, or lower alone, never while braking.
`timescale 1ns/1ps
module testbench;
    localparam int STEP = 4;
    logic clk_sys = 1'b0, sys_rst = 1'b1, ce = 1'b1, playing = 1'b0, braking = 1'b0;
    logic diag_done = 1'b0, supply_sample_valid = 1'b0, resonance_edge = 1'b0, period_averaging_disable = 1'b1;
    logic [7:0] diag_impedance = 8'h00, supply_sample = 8'h00;
    logic [1:0] mode = 2'h0;
    logic reg_rd, reg_wr, reg_rvalid, period_locked, standby_req;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
    int num_errors = 0, compares = 0, cycles = 0;
    haptic_readback_registers #(.STEP_CYCLES(STEP)) haptic_readback_registers_inst (.clk_sys, .sys_rst, .ce,
        .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .playing, .braking, .mode,
        .period_averaging_disable, .diag_done, .diag_impedance, .supply_sample_valid, .supply_sample,
        .resonance_edge, .period_locked, .standby_req);
    host_model host_model_inst (.clk_sys, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a);
        host_model_inst.access(1'b0, a, 8'h00, q);
        chk("read valid", reg_rvalid, 1);
    endtask
    // Edge to edge spacing gives exactly k whole steps
    task automatic push(input int k);
        repeat (STEP * k + 1) @(posedge clk_sys);
        resonance_edge <= 1'b1;
        @(posedge clk_sys);
        resonance_edge <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_access();
        for (int a = 3; a <= 7; a++)
        begin
            rd(8'(a));
            chk("reset value", q, 0);
        end
        @(posedge clk_sys);
        mode <= 2'h1;
        diag_impedance <= 8'h11;
        diag_done <= 1'b1;
        supply_sample <= 8'h33;
        supply_sample_valid <= 1'b1;
        @(posedge clk_sys);
        diag_done <= 1'b0;
        supply_sample_valid <= 1'b0;
        rd(8'h03);
        chk("impedance", q, 0);
        rd(8'h04);
        chk("supply", q, 0);
        @(posedge clk_sys);
        mode <= 2'h2;
        diag_impedance <= 8'h5a;
        diag_done <= 1'b1;
        playing <= 1'b1;
        supply_sample <= 8'h9c;
        supply_sample_valid <= 1'b1;
        @(posedge clk_sys);
        diag_done <= 1'b0;
        supply_sample_valid <= 1'b0;
        host_model_inst.access(1'b1, 8'h03, 8'hff, q);
        host_model_inst.access(1'b1, 8'h05, 8'hff, q);
        rd(8'h03);
        chk("impedance", q, 8'h5a);
        chk("lock", period_locked, 0);
        rd(8'h04);
        chk("supply", q, 8'h9c);
    endtask
    task automatic t_period();
        push(1);
        push(301);
        settle();
        rd(8'h05);
        chk("period upper", q, 8'h01);
        push(1);
        push(5);
        settle();
        chk("lock", period_locked, 1);
        rd(8'h06);
        chk("period lower", q, 8'h2d);
        chk("lock", period_locked, 0);
        push(1);
        push(5);
        settle();
        rd(8'h06);
        chk("period lower", q, 8'h05);
        rd(8'h05);
        chk("period upper", q, 8'h00);
        @(posedge clk_sys);
        playing <= 1'b0;
        settle();
        chk("lock", period_locked, 0);
        @(posedge clk_sys);
        playing <= 1'b1;
        push(1);
        push(6);
        settle();
        rd(8'h06);
        chk("period lower", q, 8'h06);
    endtask
    task automatic t_average();
        // Mode register would reset too; release with playback stopped
        @(posedge clk_sys);
        period_averaging_disable <= 1'b0;
        playing <= 1'b0;
        do_reset();
        @(posedge clk_sys);
        playing <= 1'b1;
        rd(8'h03);
        chk("impedance", q, 0);
        push(1);
        push(8);
        settle();
        rd(8'h06);
        chk("average", q, 8'h02);
        push(2);
        repeat (4) push(8);
        settle();
        rd(8'h06);
        chk("average", q, 8'h08);
    endtask
    task automatic t_standby();
        @(posedge clk_sys);
        braking <= 1'b1;
        for (int m = 3; m < 7; m++)
        begin
            @(posedge clk_sys);
            mode <= 2'(m);
            @(posedge clk_sys);
            #1;
            chk("standby", standby_req, 1);
            @(posedge clk_sys);
            #1;
            chk("standby", standby_req, 0);
        end
        // Enable low freezes the mode copy; change shows once enabled
        @(posedge clk_sys);
        ce <= 1'b0;
        mode <= 2'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("frozen standby", standby_req, 0);
        @(posedge clk_sys);
        ce <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("standby", standby_req, 1);
    endtask
    initial
    begin
        do_reset();
        t_access();
        t_period();
        t_average();
        t_standby();
        end_of_test();
    end
endmodule // testbench
